// ===== rtl/tcr_regs.vh
// register addresses, field positions and counter constants of the timer block
`ifndef TCR_REGS_VH
`define TCR_REGS_VH
`define TCR_ADDR_CONTROL 8'hC8
`define TCR_ADDR_COUNT_LOW 8'hCC
`define TCR_ADDR_COUNT_HIGH 8'hCD
`define TCR_ADDR_RELOAD_LOW 8'hCA
`define TCR_ADDR_RELOAD_HIGH 8'hCB
`define TCR_CONTROL_RESET 8'h00
`define TCR_BIT_OVERFLOW 7
`define TCR_BIT_EXTERNAL 6
`define TCR_BIT_RX_CLOCK 5
`define TCR_BIT_TX_CLOCK 4
`define TCR_BIT_EXT_ENABLE 3
`define TCR_BIT_RUN 2
`define TCR_BIT_COUNTER 1
`define TCR_BIT_CAPTURE 0
`define TCR_COUNT_MAX 16'hFFFF
`define TCR_WORD_ZERO 16'h0000
`define TCR_BYTE_ZERO 8'h00
`define TCR_COUNT_STEP 16'h0001
`define TCR_LOW_BYTE 7:0
`define TCR_HIGH_BYTE 15:8
`define TCR_PIN_IDLE 1'b1
`endif

// ===== rtl/tcr_edge_detect.v
// falling-edge detector for a pin sampled on the clock
`timescale 1ns/1ps
`include "tcr_regs.vh"
module tcr_edge_detect (
  input wire ref_clk,
  input wire rst,
  input wire pin_in,
  output wire fall_pulse
);
  reg last_q;

  // last sample resets high, so a pin already low at release is taken as an edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_q <= `TCR_PIN_IDLE;
    end else begin
      last_q <= pin_in;
    end
  end

  assign fall_pulse = last_q & ~pin_in;
endmodule

// ===== rtl/tcr_tick_gen.v
// count tick source: internal divided clock or external pin falling edges
`timescale 1ns/1ps
module tcr_tick_gen #(
  parameter DIV_TIMER = 12,
  parameter DIV_BAUD = 2
) (
  input wire ref_clk,
  input wire rst,
  input wire baud_mode,
  input wire use_pin,
  input wire pin_fall,
  output wire tick
);
  reg [3:0] div_q;
  wire [3:0] limit;
  wire wrap;
  // the 4-bit divider limits either ratio to at most 16
  localparam [31:0] LIMIT_TIMER = DIV_TIMER - 1;
  localparam [31:0] LIMIT_BAUD = DIV_BAUD - 1;

  // baud mode counts faster, as the internal timer divider differs there
  assign limit = baud_mode ? LIMIT_BAUD[3:0] : LIMIT_TIMER[3:0];
  assign wrap = (div_q >= limit);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= 4'h0;
    end else if (wrap) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign tick = use_pin ? pin_fall : wrap;
endmodule

// ===== rtl/tcr_timer.v
// 16-bit capture / auto-reload / baud-rate timer with its register port
`timescale 1ns/1ps
`include "tcr_regs.vh"
module tcr_timer #(
  parameter DIV_TIMER = 12,
  parameter DIV_BAUD = 2
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire trigger_pin,
  input wire count_pin,
  input wire t1_overflow,
  output wire timer_irq,
  output wire first_uart_rx_clock,
  output wire first_uart_tx_clock,
  output wire overflow_pulse
);
  reg [7:0] timer_two_control_q;
  reg [7:0] timer_two_control_d;
  reg [7:0] count_low_byte_q;
  reg [7:0] count_high_byte_q;
  reg [7:0] capture_reload_low_q;
  reg [7:0] capture_reload_high_q;
  reg [15:0] count_d;
  reg [15:0] reload_d;
  reg ovf_pulse_q;
  reg [7:0] rdata_d;
  reg wrap_loads;
  reg wrap_flags;
  reg trig_loads;
  reg trig_copies;

  wire trig_fall;
  wire cnt_fall;
  wire tick;
  wire run;
  wire ext_en;
  wire rx_sel;
  wire tx_sel;
  wire flag_ovf;
  wire flag_ext;
  wire [1:0] mode;
  wire baud_mode;
  wire capture_mode;
  wire [15:0] count;
  wire [15:0] reload;
  wire [15:0] count_inc;
  wire count_step;
  wire at_max;
  wire wrap;
  wire wrap_reload;
  wire trig_event;
  wire capture_now;
  wire trig_reload;
  wire set_overflow;
  wire set_external;
  wire wr_ctrl;
  wire wr_count_low;
  wire wr_count_high;
  wire wr_reload_low;
  wire wr_reload_high;

  // decode an address hit for a write
  function hit;
    input [7:0] addr;
    input [7:0] want;
    input we;
    begin
      hit = we & (addr == want);
    end
  endfunction

  // operating modes; the spare code is never produced by mode_of
  localparam [1:0] MODE_RELOAD = 2'h0;
  localparam [1:0] MODE_CAPTURE = 2'h1;
  localparam [1:0] MODE_BAUD = 2'h2;
  localparam [1:0] MODE_SPARE = 2'h3;

  // mode from the control byte: either clock-select bit overrides capture
  function [1:0] mode_of;
    input [7:0] ctrl;
    begin
      if (ctrl[`TCR_BIT_RX_CLOCK] | ctrl[`TCR_BIT_TX_CLOCK]) begin
        mode_of = MODE_BAUD;
      end else if (ctrl[`TCR_BIT_CAPTURE]) begin
        mode_of = MODE_CAPTURE;
      end else begin
        mode_of = MODE_RELOAD;
      end
    end
  endfunction

  tcr_edge_detect u_trig (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(trigger_pin),
    .fall_pulse(trig_fall)
  );

  tcr_edge_detect u_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(count_pin),
    .fall_pulse(cnt_fall)
  );

  tcr_tick_gen #(
    .DIV_TIMER(DIV_TIMER),
    .DIV_BAUD(DIV_BAUD)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .baud_mode(baud_mode),
    .use_pin(timer_two_control_q[`TCR_BIT_COUNTER]),
    .pin_fall(cnt_fall),
    .tick(tick)
  );

  // packed views of the byte pairs; bytes stay independent registers
  assign count = {count_high_byte_q, count_low_byte_q};
  assign reload = {capture_reload_high_q, capture_reload_low_q};

  // control bit fields, named once so the logic below stays readable
  assign run = timer_two_control_q[`TCR_BIT_RUN];
  assign ext_en = timer_two_control_q[`TCR_BIT_EXT_ENABLE];
  assign rx_sel = timer_two_control_q[`TCR_BIT_RX_CLOCK];
  assign tx_sel = timer_two_control_q[`TCR_BIT_TX_CLOCK];
  assign flag_ovf = timer_two_control_q[`TCR_BIT_OVERFLOW];
  assign flag_ext = timer_two_control_q[`TCR_BIT_EXTERNAL];

  // mode decode; baud mode also speeds up the internal divider
  assign mode = mode_of(timer_two_control_q);
  assign baud_mode = (mode == MODE_BAUD);
  assign capture_mode = (mode == MODE_CAPTURE);

  // per-mode reaction to a wrap and to a trigger edge
  always @* begin
    wrap_loads = 1'b0;
    wrap_flags = 1'b0;
    trig_loads = 1'b0;
    trig_copies = 1'b0;
    case (mode)
      MODE_CAPTURE: begin
        wrap_flags = 1'b1;
        trig_copies = 1'b1;
      end
      MODE_RELOAD: begin
        wrap_loads = 1'b1;
        wrap_flags = 1'b1;
        trig_loads = 1'b1;
      end
      MODE_BAUD: begin
        wrap_loads = 1'b1;
      end
      default: begin
        wrap_loads = 1'b0;
      end
    endcase
  end

  // one write strobe per register, so each byte sees only its own address
  assign wr_ctrl = hit(reg_addr, `TCR_ADDR_CONTROL, reg_write);
  assign wr_count_low = hit(reg_addr, `TCR_ADDR_COUNT_LOW, reg_write);
  assign wr_count_high = hit(reg_addr, `TCR_ADDR_COUNT_HIGH, reg_write);
  assign wr_reload_low = hit(reg_addr, `TCR_ADDR_RELOAD_LOW, reg_write);
  assign wr_reload_high = hit(reg_addr, `TCR_ADDR_RELOAD_HIGH, reg_write);

  // a tick only counts while the run bit is set, in every mode
  assign count_step = run & tick;
  assign at_max = (count == `TCR_COUNT_MAX);
  assign wrap = count_step & at_max;
  assign count_inc = count + `TCR_COUNT_STEP;
  assign wrap_reload = wrap & wrap_loads;

  // trigger events act whether or not the counter runs
  assign trig_event = trig_fall & ext_en;
  assign capture_now = trig_event & trig_copies;
  assign trig_reload = trig_event & trig_loads;

  // flag set sources; a baud-mode wrap is never flagged
  assign set_overflow = wrap & wrap_flags;
  assign set_external = trig_event;

  // control register next value: a hardware set beats a software clear
  always @* begin
    timer_two_control_d = timer_two_control_q;
    if (wr_ctrl) begin
      timer_two_control_d = reg_wdata;
    end
    if (set_overflow) begin
      timer_two_control_d[`TCR_BIT_OVERFLOW] = 1'b1;
    end
    if (set_external) begin
      timer_two_control_d[`TCR_BIT_EXTERNAL] = 1'b1;
    end
  end

  // count next value: a tick or trigger reload beats a software write
  always @* begin
    count_d = count;
    if (wr_count_low) begin
      count_d[`TCR_LOW_BYTE] = reg_wdata;
    end
    if (wr_count_high) begin
      count_d[`TCR_HIGH_BYTE] = reg_wdata;
    end
    if (count_step) begin
      if (wrap_reload) begin
        count_d = reload;
      end else begin
        count_d = count_inc;
      end
    end
    if (trig_reload) begin
      count_d = reload;
    end
  end

  // reload next value: a capture beats a software write
  always @* begin
    reload_d = reload;
    if (wr_reload_low) begin
      reload_d[`TCR_LOW_BYTE] = reg_wdata;
    end
    if (wr_reload_high) begin
      reload_d[`TCR_HIGH_BYTE] = reg_wdata;
    end
    if (capture_now) begin
      reload_d = count;
    end
  end

  // control register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_two_control_q <= `TCR_CONTROL_RESET;
    end else begin
      timer_two_control_q <= timer_two_control_d;
    end
  end

  // count bytes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_low_byte_q <= `TCR_BYTE_ZERO;
      count_high_byte_q <= `TCR_BYTE_ZERO;
    end else begin
      count_low_byte_q <= count_d[`TCR_LOW_BYTE];
      count_high_byte_q <= count_d[`TCR_HIGH_BYTE];
    end
  end

  // capture / reload bytes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capture_reload_low_q <= `TCR_BYTE_ZERO;
      capture_reload_high_q <= `TCR_BYTE_ZERO;
    end else begin
      capture_reload_low_q <= reload_d[`TCR_LOW_BYTE];
      capture_reload_high_q <= reload_d[`TCR_HIGH_BYTE];
    end
  end

  // overflow pulse one cycle after each wrap, in every mode
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_pulse_q <= 1'b0;
    end else begin
      ovf_pulse_q <= wrap;
    end
  end

  // read multiplexer; unmapped addresses return zero
  always @* begin
    rdata_d = `TCR_BYTE_ZERO;
    case (reg_addr)
      `TCR_ADDR_CONTROL: rdata_d = timer_two_control_q;
      `TCR_ADDR_COUNT_LOW: rdata_d = count_low_byte_q;
      `TCR_ADDR_COUNT_HIGH: rdata_d = count_high_byte_q;
      `TCR_ADDR_RELOAD_LOW: rdata_d = capture_reload_low_q;
      `TCR_ADDR_RELOAD_HIGH: rdata_d = capture_reload_high_q;
      default: rdata_d = `TCR_BYTE_ZERO;
    endcase
  end

  // read data is registered and holds until the next read
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `TCR_BYTE_ZERO;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  // level request from stored flags, so it stays until software clears both
  assign timer_irq = flag_ovf | flag_ext;
  assign overflow_pulse = ovf_pulse_q;
  // uart clocks fall back to timer 1 overflow when not selected
  assign first_uart_rx_clock = rx_sel ? ovf_pulse_q : t1_overflow;
  assign first_uart_tx_clock = tx_sel ? ovf_pulse_q : t1_overflow;
endmodule

// ===== test/tcr_pin_model.sv
// far-side pin model: trigger pin, count pin, timer 1 overflow
`timescale 1ns/1ps
module tcr_pin_model (
  input wire ref_clk,
  input wire trig_req,
  input wire cnt_req,
  output logic trigger_pin = 1'b1,
  output logic count_pin = 1'b1,
  output logic t1_overflow = 1'b0
);
  logic [2:0] div_q = 3'h0;
  // pins idle high as if pulled up; a request pulls them low after the edge
  always @(posedge ref_clk) begin
    div_q <= div_q + 3'h1;
    t1_overflow <= #1 (div_q == 3'h4);
    trigger_pin <= #1 !trig_req;
    count_pin <= #1 !cnt_req;
  end
endmodule

// ===== test/tcr_timer_assertions.sv
// port checker of the timer block
`timescale 1ns/1ps
module tcr_chk (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire trigger_pin,
  input wire t1_overflow,
  input wire timer_irq,
  input wire first_uart_rx_clock,
  input wire first_uart_tx_clock,
  input wire overflow_pulse
);
  logic [5:0] c_q;
  // mirror of software-only control bits; flags are not mirrored
  always @(posedge ref_clk or posedge rst)
    if (rst) c_q <= 6'h00;
    else if (reg_write && reg_addr == 8'hC8) c_q <= reg_wdata[5:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rx; first_uart_rx_clock ==
    (c_q[5] ? overflow_pulse : t1_overflow); endproperty
  a_rx: assert property (p_rx) else $error("rx clock");
  property p_tx; first_uart_tx_clock ==
    (c_q[4] ? overflow_pulse : t1_overflow); endproperty
  a_tx: assert property (p_tx) else $error("tx clock");
  property p_ovf; overflow_pulse && $past(c_q[5:4]) == 2'h0
    |-> timer_irq; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag");
  property p_run; !c_q[2] |=> !overflow_pulse; endproperty
  a_run: assert property (p_run) else $error("counted while off");
  property p_baud; (|c_q[5:4]) && !c_q[3] && !timer_irq && !reg_write
    |=> !timer_irq; endproperty
  a_baud: assert property (p_baud) else $error("baud irq");
  property p_sticky; timer_irq && !(reg_write && reg_addr == 8'hC8)
    |=> timer_irq; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_ext; $fell(trigger_pin) && c_q[3] |=> timer_irq; endproperty
  a_ext: assert property (p_ext) else $error("ext flag");
  property p_unm; reg_read && reg_addr == 8'hC9
    |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rdc; reg_read && reg_addr == 8'hC8 |=> {|reg_rdata[7:6],
    reg_rdata[5:0]} == {$past(timer_irq), $past(c_q)}; endproperty
  a_rdc: assert property (p_rdc) else $error("control read");
endmodule
bind tcr_timer tcr_chk u_chk (.*);

// ===== test/tb_timer2_capture_reload_baud.sv
// self-checking bench of the timer block
`timescale 1ns/1ps
module tb_timer2_capture_reload_baud;
  logic ref_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic trig_req = 1'b0, cnt_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire trigger_pin, count_pin, t1_overflow, timer_irq, overflow_pulse;
  wire first_uart_rx_clock, first_uart_tx_clock;
  int n_mismatch = 0, compares = 0;
  always #10 ref_clk = ~ref_clk;
  // tick every clock outside baud mode keeps the timer runs short
  tcr_timer #(.DIV_TIMER(1)) dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .trigger_pin, .count_pin,
    .t1_overflow, .timer_irq, .first_uart_rx_clock, .first_uart_tx_clock,
    .overflow_pulse);
  tcr_pin_model pins (.ref_clk, .trig_req, .cnt_req, .trigger_pin,
    .count_pin, .t1_overflow);
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk) #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge ref_clk) #1 reg_write = 1'b0;
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk) #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge ref_clk) #1 reg_read = 1'b0;
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  // request held two cycles so the pin stays low long enough to be seen
  // sel low drives the trigger pin, sel high the count pin
  task automatic pulse(logic sel);
    @(posedge ref_clk) #1;
    if (sel) cnt_req = 1'b1;
    else trig_req = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 trig_req = 1'b0;
    cnt_req = 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wait_ovf;
    for (int i = 0; i < 200 && overflow_pulse !== 1'b1; i++)
      @(posedge ref_clk) #1;
    chk("ovf", 8'h01, {7'h00, overflow_pulse});
  endtask
  task s_reset;
    rc(8'hC8, 8'h00);
    rc(8'hC9, 8'h00);
  endtask
  task s_capture;
    wr(8'hCC, 8'h34);
    wr(8'hCD, 8'h12);
    wr(8'hC8, 8'h09);
    pulse(1'b0);
    rc(8'hCA, 8'h34);
    rc(8'hCB, 8'h12);
    rc(8'hC8, 8'h49);
    rc(8'hCC, 8'h34);
    wr(8'hCC, 8'hF0);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h05);
    wait_ovf;
    rc(8'hC8, 8'h85);
    wr(8'hC8, 8'h01);
    rc(8'hCD, 8'h00);
  endtask
  task s_reload;
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h04);
    wait_ovf;
    rc(8'hC8, 8'h84);
    wr(8'hC8, 8'h08);
    wr(8'hCA, 8'hCD);
    wr(8'hCB, 8'hAB);
    pulse(1'b0);
    rc(8'hCC, 8'hCD);
    rc(8'hCD, 8'hAB);
    rc(8'hC8, 8'h48);
  endtask
  task s_baud;
    wr(8'hCB, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h35);
    wait_ovf;
    chk("irq", 8'h00, {7'h00, timer_irq});
    wr(8'hC8, 8'h31);
    rc(8'hCD, 8'hFF);
    wr(8'hCC, 8'h11);
    wr(8'hC8, 8'h38);
    pulse(1'b0);
    rc(8'hC8, 8'h78);
    rc(8'hCC, 8'h11);
  endtask
  task s_counter;
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h06);
    repeat (3) pulse(1'b1);
    rc(8'hCC, 8'h03);
  endtask
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog: whole run needs about 300 cycles
  initial begin
    #100us;
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    s_reset;
    s_capture;
    s_reload;
    s_baud;
    s_counter;
    stop_test;
  end
endmodule
